// ==== rtl/hdlc_holdover_ctrl.sv ====
// Functional notes
// - With rail detection on, a DAC at a trip level while tracking enters holdover and raises a switch event.
// - In manual mode the DAC is driven from the 10-bit programmed code.
// - The mode bit picks tracking (0) or the manual code (1) as DAC source.
// - Holdover is left only after lock stays valid for the programmed 14-bit count of cycles.
// - The force bit puts the block in holdover, and in fixed mode the DAC shows the manual code.
// - Forced holdover in tracked mode freezes the DAC at its current tracked value.
// - Forced holdover gives a switch event only when lock-loss switching is enabled.
// - The tracked 10-bit DAC count reads back at bits 23 to 14.
// - The lock counter counts up while the phase error is under the selected window.
// - The DAC update rate is the core clock divided by a 10-bit divisor.
// - Lock detect asserts only after the programmed 14-bit count of in-window phase samples.
// - A falling lock flag causes a switch event and holdover unless lock-loss switching is off.
// - Two 6-bit rail thresholds, from supply and from ground, in 1/64 supply steps.
`timescale 1ns/1ps
`default_nettype none
module hdlc_holdover_ctrl
	import hdlc_pkg::*;
(
	input  wire logic                            core_clk,
	input  wire logic                            rst,
	input  wire logic                            prog_clk,
	input  wire logic                            prog_data,
	input  wire logic                            prog_latch,
	output logic                                 readback_data,
	input  wire logic                            lock_loss_switch_disable,
	input  wire logic                            phase_sample,
	input  wire logic [hdlc_pkg::PHASE_W-1:0]    phase_error_ps,
	input  wire logic                            track_up,
	input  wire logic                            track_down,
	output logic [hdlc_pkg::DAC_W-1:0]           dac_code,
	output logic                                 ref_pll_lock_flag,
	output logic                                 holdover_active,
	output logic                                 clock_switch_event,
	output logic                                 rail_high_flag,
	output logic                                 rail_low_flag,
	output logic [hdlc_pkg::XTAL_W-1:0]          crystal_level
);
	import hdlc_pkg::*;

	logic [2:0]          clk_sync_q;
	logic [2:0]          data_sync_q;
	logic [2:0]          latch_sync_q;
	logic                clk_rise;
	logic                latch_rise;
	logic [WORD_W-1:0]   shift_q;
	logic [WORD_W-1:0]   rb_shift_q;
	logic [WORD_W-1:0]   input_mon_q;
	logic [WORD_W-1:0]   dac_hold_q;
	logic [WORD_W-1:0]   crystal_q;
	logic [WORD_W-1:0]   lf_delay_q;
	logic [WORD_W-1:0]   dac_clk_lock_q;
	logic [ADDR_W-1:0]   wr_addr;
	logic [WORD_W-1:0]   readback_word;

	logic                tune_rail_detect_enable;
	logic [TRIP_W-1:0]   high_trip;
	logic [TRIP_W-1:0]   low_trip;
	logic [DAC_W-1:0]    manual_dac_code;
	logic                manual_dac_select;
	logic [CNT_W-1:0]    holdover_exit_count;
	logic                force_holdover;
	logic [WND_W-1:0]    ref_pll_lock_window;
	logic [DAC_W-1:0]    dac_clk_div;
	logic [CNT_W-1:0]    ref_pll_lock_count;

	logic [PHASE_W-1:0]  window_ps;
	logic [CNT_W-1:0]    lock_cnt_q;
	logic [CNT_W-1:0]    lock_need;
	logic                raw_lock;
	logic                lock_flag_d;
	logic                lock_fall;

	hdlc_hold_state_type state_q;
	logic [CNT_W-1:0]    exit_cnt_q;
	logic [CNT_W-1:0]    exit_need;

	logic                dac_tick;
	logic [DAC_W-1:0]    tracked_dac_count_q;
	logic [16:0]         high_lhs;
	logic [16:0]         low_lhs;
	logic [16:0]         high_rhs;
	logic [16:0]         low_rhs;
	logic                rail_high;
	logic                rail_low;
	logic                rail_trip;
	logic                rail_event;
	logic                enter_hold;

	// Pin synchronisers, stage 0 feeds only stage 1
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			clk_sync_q   <= '0;
			data_sync_q  <= '0;
			latch_sync_q <= '0;
		end
		else
		begin
			clk_sync_q   <= {clk_sync_q[1:0], prog_clk};
			data_sync_q  <= {data_sync_q[1:0], prog_data};
			latch_sync_q <= {latch_sync_q[1:0], prog_latch};
		end
	end

	assign clk_rise   = clk_sync_q[1] & ~clk_sync_q[2];
	assign latch_rise = latch_sync_q[1] & ~latch_sync_q[2];
	assign wr_addr    = shift_q[ADDR_W-1:0];

	// Serial word in, MSB first
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			shift_q <= '0;
		else if (clk_rise)
			shift_q <= {shift_q[WORD_W-2:0], data_sync_q[1]};
	end

	// Register writes on latch rise
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			input_mon_q    <= RST_INPUT_MON;
			dac_hold_q     <= RST_DAC_HOLD;
			crystal_q      <= RST_CRYSTAL;
			lf_delay_q     <= RST_LF_DELAY;
			dac_clk_lock_q <= RST_DAC_CLK_LOCK;
		end
		else if (latch_rise)
		begin
			case (wr_addr)
				ADDR_INPUT_MON:    input_mon_q    <= shift_q;
				ADDR_DAC_HOLD:     dac_hold_q     <= shift_q;
				ADDR_CRYSTAL:      crystal_q      <= shift_q;
				ADDR_LF_DELAY:     lf_delay_q     <= shift_q;
				ADDR_DAC_CLK_LOCK: dac_clk_lock_q <= shift_q;
				default:           ;
			endcase
		end
	end

	assign tune_rail_detect_enable = input_mon_q[RAIL_EN_BIT];
	assign high_trip               = input_mon_q[HIGH_TRIP_LSB +: TRIP_W];
	assign low_trip                = input_mon_q[LOW_TRIP_LSB +: TRIP_W];
	assign manual_dac_code         = dac_hold_q[MANUAL_DAC_CODE_LSB +: DAC_W];
	assign manual_dac_select       = dac_hold_q[MAN_SEL_BIT];
	assign holdover_exit_count     = dac_hold_q[EXIT_CNT_LSB +: CNT_W];
	assign force_holdover          = dac_hold_q[FORCE_BIT];
	assign ref_pll_lock_window     = lf_delay_q[WND_LSB +: WND_W];
	assign dac_clk_div             = dac_clk_lock_q[DAC_DIV_LSB +: DAC_W];
	assign ref_pll_lock_count      = dac_clk_lock_q[LOCK_CNT_LSB +: CNT_W];
	assign crystal_level           = crystal_q[XTAL_LSB +: XTAL_W];

	assign readback_word = {8'h00, tracked_dac_count_q, 14'h0000};

	// Readback word loads on a request, shifts out MSB first
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rb_shift_q <= '0;
		else if (latch_rise && wr_addr == ADDR_DAC_READBACK)
			rb_shift_q <= readback_word;
		else if (clk_rise)
			rb_shift_q <= {rb_shift_q[WORD_W-2:0], 1'b0};
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			readback_data <= 1'b0;
		else
			readback_data <= rb_shift_q[WORD_W-1];
	end

	always_comb
	begin
		case (ref_pll_lock_window)
			2'h0:    window_ps = WND0_PS;
			2'h1:    window_ps = WND1_PS;
			2'h2:    window_ps = WND2_PS;
			default: window_ps = WND3_PS;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			lock_cnt_q <= '0;
		else if (phase_sample)
		begin
			if (phase_error_ps >= window_ps)
				lock_cnt_q <= '0;
			else if (lock_cnt_q != {CNT_W{1'b1}})
				lock_cnt_q <= lock_cnt_q + CNT_W'(1);
		end
	end

	assign lock_need   = (ref_pll_lock_count == '0) ? CNT_W'(1) : ref_pll_lock_count;
	assign raw_lock    = lock_cnt_q >= lock_need;
	assign lock_flag_d = raw_lock && state_q == ST_TRACK;
	assign lock_fall   = ref_pll_lock_flag && !lock_flag_d;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ref_pll_lock_flag <= 1'b0;
		else
			ref_pll_lock_flag <= lock_flag_d;
	end

	assign high_lhs  = 17'((DAC_FULL_SCALE - {7'h00, dac_code}) << TRIP_STEP_LOG2);
	assign low_lhs   = 17'({7'h00, dac_code} << TRIP_STEP_LOG2);
	assign high_rhs  = 17'(({11'h000, high_trip} + 17'h00001) * DAC_FULL_SCALE);
	assign low_rhs   = 17'(({11'h000, low_trip} + 17'h00001) * DAC_FULL_SCALE);
	assign rail_high = high_lhs <= high_rhs;
	assign rail_low  = low_lhs <= low_rhs;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rail_high_flag <= 1'b0;
			rail_low_flag  <= 1'b0;
		end
		else
		begin
			rail_high_flag <= rail_high;
			rail_low_flag  <= rail_low;
		end
	end

	assign rail_trip  = tune_rail_detect_enable && (rail_high || rail_low);
	assign rail_event = rail_trip && state_q == ST_TRACK;

	assign enter_hold = force_holdover || rail_event || (lock_fall && !lock_loss_switch_disable);
	assign exit_need  = (holdover_exit_count == '0) ? CNT_W'(1) : holdover_exit_count;

	// Holdover state and exit counter
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q    <= ST_TRACK;
			exit_cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				ST_TRACK:
				begin
					exit_cnt_q <= '0;
					if (enter_hold)
						state_q <= ST_HOLD;
				end
				ST_HOLD:
				begin
					if (force_holdover || !raw_lock)
						exit_cnt_q <= '0;
					else if (exit_cnt_q + CNT_W'(1) >= exit_need)
					begin
						exit_cnt_q <= '0;
						state_q    <= ST_TRACK;
					end
					else
						exit_cnt_q <= exit_cnt_q + CNT_W'(1);
				end
				default:
				begin
					state_q    <= ST_TRACK;
					exit_cnt_q <= '0;
				end
			endcase
		end
	end

	assign holdover_active = state_q == ST_HOLD;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			clock_switch_event <= 1'b0;
		else
			clock_switch_event <= rail_event || (lock_fall && !lock_loss_switch_disable);
	end

	hdlc_tick_div #(
		.DIV_W (DAC_W)
	) u_dac_div (
		.core_clk (core_clk),
		.rst      (rst),
		.divisor  (dac_clk_div),
		.tick     (dac_tick)
	);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			tracked_dac_count_q <= '0;
		else if (dac_tick && state_q == ST_TRACK && !manual_dac_select)
		begin
			if (track_up && !track_down && tracked_dac_count_q != {DAC_W{1'b1}})
				tracked_dac_count_q <= tracked_dac_count_q + DAC_W'(1);
			else if (track_down && !track_up && tracked_dac_count_q != '0)
				tracked_dac_count_q <= tracked_dac_count_q - DAC_W'(1);
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			dac_code <= '0;
		else if (manual_dac_select)
			dac_code <= manual_dac_code;
		else
			dac_code <= tracked_dac_count_q;
	end

endmodule // hdlc_holdover_ctrl
`default_nettype wire

// ==== common/hdlc_pkg.sv ====
`default_nettype none
package hdlc_pkg;

	// Serial register port
	localparam int          WORD_W            = 32;
	localparam int          ADDR_W            = 5;
	localparam logic [4:0]  ADDR_INPUT_MON    = 5'h0e;
	localparam logic [4:0]  ADDR_DAC_HOLD     = 5'h0f;
	localparam logic [4:0]  ADDR_CRYSTAL      = 5'h10;
	localparam logic [4:0]  ADDR_DAC_READBACK = 5'h17;
	localparam logic [4:0]  ADDR_LF_DELAY     = 5'h18;
	localparam logic [4:0]  ADDR_DAC_CLK_LOCK = 5'h19;

	// input_monitor_config fields
	localparam int TRIP_W        = 6;
	localparam int HIGH_TRIP_LSB = 14;
	localparam int LOW_TRIP_LSB  = 6;
	localparam int RAIL_EN_BIT   = 5;

	// dac_holdover_config fields
	localparam int DAC_W        = 10;
	localparam int MANUAL_DAC_CODE_LSB  = 22;
	localparam int MAN_SEL_BIT  = 20;
	localparam int CNT_W        = 14;
	localparam int EXIT_CNT_LSB = 6;
	localparam int FORCE_BIT    = 5;

	// crystal_level_config field
	localparam int XTAL_W   = 2;
	localparam int XTAL_LSB = 22;

	// loop_filter_delay_window field
	localparam int WND_W   = 2;
	localparam int WND_LSB = 6;

	// dac_clock_lock_count fields
	localparam int DAC_DIV_LSB  = 22;
	localparam int LOCK_CNT_LSB = 6;

	// dac_count_readback field
	localparam int READBACK_DAC_LSB = 14;

	// DAC scaling and rail steps
	localparam logic [16:0] DAC_FULL_SCALE = 17'h003ff;
	localparam int          TRIP_STEP_LOG2 = 6;

	// Lock windows in picoseconds
	localparam logic [15:0] WND0_PS = 16'h157c;
	localparam logic [15:0] WND1_PS = 16'h2710;
	localparam logic [15:0] WND2_PS = 16'h48a8;
	localparam logic [15:0] WND3_PS = 16'h9c40;
	localparam int          PHASE_W = 16;

	// Reset values
	localparam logic [31:0] RST_INPUT_MON    = 32'h0000_0000;
	localparam logic [31:0] RST_DAC_HOLD     = 32'h0000_0040;
	localparam logic [31:0] RST_CRYSTAL      = 32'h0000_0000;
	localparam logic [31:0] RST_LF_DELAY     = 32'h0000_0000;
	localparam logic [31:0] RST_DAC_CLK_LOCK = 32'h0040_0040;

	typedef enum logic {
		ST_TRACK,
		ST_HOLD
	} hdlc_hold_state_type;

endpackage
`default_nettype wire

// ==== rtl/hdlc_tick_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module hdlc_tick_div #(
	parameter int DIV_W = 10
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [DIV_W-1:0] divisor,
	output logic                  tick
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] last;

	// Code 0 is reserved, run it as divide by one
	assign last = (divisor == '0) ? '0 : divisor - DIV_W'(1);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end
		else if (cnt_q >= last)
		begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + DIV_W'(1);
			tick  <= 1'b0;
		end
	end
endmodule // hdlc_tick_div
`default_nettype wire

// ==== testbench/hdlc_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module hdlc_props
	import hdlc_pkg::*;
(
	input wire logic                         core_clk,
	input wire logic                         rst,
	input wire logic                         prog_latch,
	input wire logic                         lock_loss_switch_disable,
	input wire logic                         phase_sample,
	input wire logic [hdlc_pkg::PHASE_W-1:0] phase_error_ps,
	input wire logic [hdlc_pkg::DAC_W-1:0]   dac_code,
	input wire logic                         ref_pll_lock_flag,
	input wire logic                         holdover_active,
	input wire logic                         clock_switch_event,
	input wire logic                         rail_high_flag,
	input wire logic                         rail_low_flag
);
	logic [3:0] quiet_q;

	// Cycles since the last register commit
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			quiet_q <= 4'h0;
		else if (prog_latch)
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hf)
			quiet_q <= quiet_q + 4'h1;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_hold_lock_low: assert property (holdover_active && $past(holdover_active) |-> !ref_pll_lock_flag)
		else $error("lock flag high in holdover");
	a_fall_event: assert property ($fell(ref_pll_lock_flag) && !lock_loss_switch_disable |-> ##[0:2] clock_switch_event)
		else $error("lock fall without switch event");
	a_fall_holdover: assert property ($fell(ref_pll_lock_flag) && !lock_loss_switch_disable |-> ##[0:2] holdover_active)
		else $error("lock fall without holdover");
	a_event_cause: assert property (clock_switch_event |-> rail_high_flag || rail_low_flag
		|| $past(ref_pll_lock_flag) || $past(ref_pll_lock_flag, 2))
		else $error("switch event without cause");
	a_lock_in_track: assert property ($rose(ref_pll_lock_flag) |-> !$past(holdover_active))
		else $error("lock flag rose in holdover");
	a_out_window: assert property (phase_sample && phase_error_ps >= 16'h9c40 |-> ##[1:3] !ref_pll_lock_flag)
		else $error("lock flag kept after wide error");
	a_dac_frozen: assert property (holdover_active && $past(holdover_active) && $past(holdover_active, 2)
		&& quiet_q == 4'hf |-> $stable(dac_code))
		else $error("dac moved in holdover");
	a_dac_slew: assert property (quiet_q == 4'hf |-> dac_code == $past(dac_code)
		|| dac_code == $past(dac_code) + 10'h1 || dac_code == $past(dac_code) - 10'h1)
		else $error("dac stepped by more than one");

	c_lock: cover property ($rose(ref_pll_lock_flag));
	c_event: cover property (clock_switch_event);
	c_exit: cover property ($fell(holdover_active));
endmodule // hdlc_props
`default_nettype wire

// ==== testbench/tb_holdover_dac_lock_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_holdover_dac_lock_control;
	import hdlc_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        prog_clk = 1'b0;
	logic        prog_data = 1'b0;
	logic        prog_latch = 1'b0;
	logic        lock_loss_switch_disable = 1'b0;
	logic        phase_sample = 1'b0;
	logic [15:0] phase_error_ps = 16'h0000;
	logic        track_up = 1'b0;
	logic        track_down = 1'b0;
	logic        readback_data;
	logic [9:0]  dac_code;
	logic        ref_pll_lock_flag;
	logic        holdover_active;
	logic        clock_switch_event;
	logic        rail_high_flag;
	logic        rail_low_flag;
	logic [1:0]  crystal_level;
	logic [15:0] thr [4] = '{WND0_PS, WND1_PS, WND2_PS, WND3_PS};
	logic [31:0] w;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          ev_n = 0;
	int          n0;

	hdlc_holdover_ctrl u_dut (
		.core_clk(core_clk), .rst(rst), .prog_clk(prog_clk), .prog_data(prog_data),
		.prog_latch(prog_latch), .readback_data(readback_data),
		.lock_loss_switch_disable(lock_loss_switch_disable), .phase_sample(phase_sample),
		.phase_error_ps(phase_error_ps), .track_up(track_up), .track_down(track_down),
		.dac_code(dac_code), .ref_pll_lock_flag(ref_pll_lock_flag), .holdover_active(holdover_active),
		.clock_switch_event(clock_switch_event), .rail_high_flag(rail_high_flag),
		.rail_low_flag(rail_low_flag), .crystal_level(crystal_level)
	);

	always #10 core_clk = ~core_clk;

	always @(negedge core_clk)
		if (clock_switch_event === 1'b1)
			ev_n++;

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic send(input logic [31:0] v);
		for (int i = 31; i >= 0; i--)
		begin
			prog_data <= v[i];
			tick(4);
			prog_clk <= 1'b1;
			tick(4);
			prog_clk <= 1'b0;
			tick(1);
		end
		tick(3);
		prog_latch <= 1'b1;
		tick(4);
		prog_latch <= 1'b0;
		tick(8);
	endtask

	task automatic rd(output logic [31:0] v);
		send({27'h0, ADDR_DAC_READBACK});
		for (int i = 31; i >= 0; i--)
		begin
			v[i] = readback_data;
			prog_clk <= 1'b1;
			tick(4);
			prog_clk <= 1'b0;
			tick(4);
		end
	endtask

	task automatic ph(input logic [15:0] e, input int n);
		repeat (n)
		begin
			phase_sample <= 1'b1;
			phase_error_ps <= e;
			tick(1);
			phase_sample <= 1'b0;
			tick(1);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		#1_000_000;
		bad_count++;
		wrap_up();
	end

	initial
	begin
		tick(6);
		rst <= 1'b0;
		tick(2);
		send(32'h00c0_0011);
		chk(crystal_level, 0);
		send(32'h0080_0010);
		chk(crystal_level, 2);
		rd(w);
		chk(w, 0);
		$display("register access test done");

		lock_loss_switch_disable <= 1'b1;
		send(32'h0040_00d9);
		for (int k = 0; k < 4; k++)
		begin
			send(32'h18 | (k << 6));
			n0 = ev_n;
			ph(thr[k], 3);
			chk(ref_pll_lock_flag, 0);
			ph(thr[k] - 16'h1, 2);
			chk(ref_pll_lock_flag, 0);
			ph(thr[k] - 16'h1, 1);
			chk(ref_pll_lock_flag, 1);
			ph(thr[k], 1);
			tick(3);
			chk(ref_pll_lock_flag, 0);
			chk(ev_n - n0, 0);
			chk(holdover_active, 0);
		end
		$display("lock window test done");

		lock_loss_switch_disable <= 1'b0;
		send(32'h0000_020f);
		n0 = ev_n;
		ph(16'h0010, 3);
		ph(16'hffff, 1);
		tick(3);
		chk(ev_n - n0, 1);
		chk(holdover_active, 1);
		ph(16'h0010, 3);
		tick(4);
		ph(16'hffff, 1);
		ph(16'h0010, 3);
		tick(2);
		chk(holdover_active, 1);
		tick(4);
		chk(holdover_active, 1);
		tick(1);
		chk(holdover_active, 0);
		tick(1);
		chk(ref_pll_lock_flag, 1);
		$display("holdover exit test done");

		send(32'h0100_00d9);
		track_up <= 1'b1;
		tick(40);
		track_up <= 1'b0;
		tick(2);
		chk(dac_code, 10);
		rd(w);
		chk(w, 32'h0002_8000);
		track_down <= 1'b1;
		tick(8);
		track_down <= 1'b0;
		tick(2);
		chk(dac_code, 8);
		$display("tracking test done");

		n0 = ev_n;
		send(32'h0000_022f);
		chk(holdover_active, 1);
		chk(ev_n - n0, 1);
		track_up <= 1'b1;
		tick(40);
		track_up <= 1'b0;
		chk(dac_code, 8);
		send(32'ha950_022f);
		chk(dac_code, 32'h2a5);
		send(32'h5550_020f);
		ph(16'h0010, 6);
		tick(10);
		chk(holdover_active, 0);
		chk(dac_code, 32'h155);
		send(32'h0000_020f);
		chk(dac_code, 8);
		$display("forced holdover test done");

		lock_loss_switch_disable <= 1'b1;
		// Drop lock first so the rail holdover is not left again
		ph(16'hffff, 1);
		n0 = ev_n;
		send(32'h0000_0fee);
		chk(ev_n - n0, 1);
		chk(holdover_active, 1);
		chk(rail_low_flag, 1);
		chk(rail_high_flag, 0);
		// Trip edges with both thresholds at one step
		send(32'h0000_000e);
		send(32'hfc10_020f);
		chk(rail_high_flag, 1);
		send(32'hfbd0_020f);
		chk(rail_high_flag, 0);
		send(32'h03d0_020f);
		chk(rail_low_flag, 1);
		send(32'h0410_020f);
		chk(rail_low_flag, 0);
		$display("rail detect test done");
		wrap_up();
	end
endmodule // tb_holdover_dac_lock_control

bind hdlc_holdover_ctrl hdlc_props u_props (
	.core_clk(core_clk), .rst(rst), .prog_latch(prog_latch),
	.lock_loss_switch_disable(lock_loss_switch_disable), .phase_sample(phase_sample),
	.phase_error_ps(phase_error_ps), .dac_code(dac_code), .ref_pll_lock_flag(ref_pll_lock_flag),
	.holdover_active(holdover_active), .clock_switch_event(clock_switch_event),
	.rail_high_flag(rail_high_flag), .rail_low_flag(rail_low_flag)
);
`default_nettype wire
